// file: dv/prn_partner.sv
// Printer mechanics stand-in driving the sensor and switch lines
`timescale 1ns/10ps
module prn_partner (
	input wire logic [6:0] sense_on,
	input wire logic [7:0] press_on,
	output logic [6:0] sensor_n,
	output logic [7:0] switch_n
);
	// Lines pulled low while active
	assign sensor_n = ~sense_on;
	assign switch_n = ~press_on;
endmodule // prn_partner

// file: dv/tb_top.sv
// Self-checking bench for the printer I/O register bank
`timescale 1ns/10ps
module tb_top;
	import prn_io_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	io_write_t io_wr = '0;
	motor_drive_t [3:0] motor_drive;
	logic [3:0] microstep_phase, panel_lamps;
	logic hammer_fire, motor_power_en, print_count_pulse;
	logic [7:0] segments_n, sensor_port, switch_port, switch_n;
	logic [6:0] sensor_n;
	logic [6:0] sense_on = 7'h05;
	logic [7:0] press_on = 8'hA3;
	int err_total = 0;
	int check_count = 0;
	// Rows: write address, data, address looked at, expected view
	logic [31:0] rows [10] = '{32'h5C205C20, 32'h581F581F, 32'h59155915, 32'h5A0A5A0A,
		32'h5B135B13, 32'h54FF540F, 32'h5FA55FA5, 32'h5C3F5C3F, 32'h5C1F5C00, 32'h5DFF5810};
	always #5 ref_clk = ~ref_clk;
	printer_io_register_bank uut (.ref_clk(ref_clk), .arst_n(arst_n), .io_wr(io_wr),
		.motor_drive(motor_drive), .microstep_phase(microstep_phase),
		.hammer_fire(hammer_fire), .motor_power_en(motor_power_en),
		.panel_lamps(panel_lamps), .segments_n(segments_n),
		.print_count_pulse(print_count_pulse), .sensor_n(sensor_n), .switch_n(switch_n),
		.sensor_port(sensor_port), .switch_port(switch_port));
	prn_partner mech (.sense_on(sense_on), .press_on(press_on), .sensor_n(sensor_n),
		.switch_n(switch_n));
	// ==========================================
	// Helpers
	function automatic logic [7:0] obs(input logic [7:0] a);
		case (a)
			ADDR_LAMPS: obs = {4'h0, panel_lamps};
			ADDR_CONTROL: obs = {2'h0, motor_power_en, hammer_fire, microstep_phase};
			ADDR_SEGMENTS: obs = segments_n;
			default: obs = {3'h0, motor_drive[a[1:0]].hold_n, motor_drive[a[1:0]].phase};
		endcase
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		io_wr = '{wr: 1'b1, addr: a, data: d};
		@(negedge ref_clk);
		io_wr.wr = 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (3) @(negedge ref_clk);
		check("motor reset", obs(8'h58), 8'h00);
		check("control reset", obs(ADDR_CONTROL), 8'h00);
		arst_n = 1'b1;
		$display("reset test done");
		foreach (rows[i]) begin
			// Write each row's address and data, then check the view at the address looked at
			put(rows[i][31:24], rows[i][23:16]);
			check("row view", obs(rows[i][15:8]), rows[i][7:0]);
		end
		$display("row tests done");
		check("sensor port", sensor_port, {1'b1, ~sense_on});
		check("switch port", switch_port, ~press_on);
		put(ADDR_COUNTER, 8'h00);
		check("count pulse", {7'h0, print_count_pulse}, 8'h01);
		@(negedge ref_clk);
		check("count pulse end", {7'h0, print_count_pulse}, 8'h00);
		$display("counter test done");
		arst_n = 1'b0;
		@(negedge ref_clk);
		check("lamps reset", obs(ADDR_LAMPS), 8'h00);
		check("motor held", obs(8'h58), 8'h00);
		$display("second reset test done");
		finish_test;
	end
	initial begin
		#20000;
		err_total++;
		$display("watchdog expired");
		finish_test;
	end
endmodule // tb_top

// file: rtl/io_out_reg.sv
// One byte-wide output register loaded by a decoded write strobe
`timescale 1ns/10ps
module io_out_reg (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic load,
	input wire logic [7:0] din,
	output logic [7:0] q
);
	import prn_io_pkg::*;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= RESET_REG;
		end else if (load) begin
			q <= din;
		end
	end
endmodule // io_out_reg

// file: rtl/printer_io_register_bank.sv
// Printer-side I/O register bank: motor, control, lamp, display and input ports
`timescale 1ns/10ps
module printer_io_register_bank (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire prn_io_pkg::io_write_t io_wr,
	output prn_io_pkg::motor_drive_t [3:0] motor_drive,
	output logic [3:0] microstep_phase,
	output logic hammer_fire,
	output logic motor_power_en,
	output logic [3:0] panel_lamps,
	output logic [7:0] segments_n,
	output logic print_count_pulse,
	input wire logic [6:0] sensor_n,
	input wire logic [7:0] switch_n,
	output logic [7:0] sensor_port,
	output logic [7:0] switch_port
);
	import prn_io_pkg::*;

	// ==========================================================
	// Address decode
	wire logic [3:0] motor_sel;
	wire logic control_sel;
	wire logic lamps_sel;
	wire logic segments_sel;
	wire logic counter_sel;
	wire logic any_sel;
	logic [7:0] motor_reg [NUM_MOTORS];
	logic [7:0] control_reg;
	logic [7:0] lamps_reg;
	logic [7:0] segments_reg;
	logic pulse;

	assign control_sel = io_wr.wr && (io_wr.addr == ADDR_CONTROL);
	assign lamps_sel = io_wr.wr && (io_wr.addr == ADDR_LAMPS);
	assign segments_sel = io_wr.wr && (io_wr.addr == ADDR_SEGMENTS);
	assign counter_sel = io_wr.wr && (io_wr.addr == ADDR_COUNTER);
	// Any decoded write; unmapped addresses leave every register alone
	assign any_sel = (|motor_sel) || control_sel || lamps_sel || segments_sel || counter_sel;

	// ==========================================================
	// Motor registers, daisy first
	genvar i;
	generate
		for (i = 0; i < NUM_MOTORS; i++) begin : g_motor
			assign motor_sel[i] = io_wr.wr && (io_wr.addr == ADDR_DAISY + 8'(i));
			io_out_reg u_reg (
				.ref_clk(ref_clk),
				.arst_n(arst_n),
				.load(motor_sel[i]),
				.din(io_wr.data),
				.q(motor_reg[i])
			);
			// Phases forced low without motor enable
			assign motor_drive[i].phase = control_reg[ENABLE_BIT] ?
				motor_reg[i][PHASE_LSB +: 4] : PHASE_OFF;
			assign motor_drive[i].hold_n = motor_reg[i][HOLD_BIT];

			// Per-motor checks
			AST_MOTOR_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
				motor_sel[i] |=> motor_drive[i].hold_n == $past(io_wr.data[HOLD_BIT]))
				else $error("motor hold line not loaded");
			AST_MOTOR_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
				!motor_sel[i] |=> $stable(motor_reg[i]))
				else $error("motor register changed without write");
			AST_MOTOR_GATE: assert property (@(posedge ref_clk) disable iff (!arst_n)
				!motor_power_en |-> motor_drive[i].phase == PHASE_OFF)
				else $error("motor phases driven while disabled");
			AST_MOTOR_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
				motor_sel[i] && control_reg[ENABLE_BIT] && !control_sel
				|=> motor_drive[i].phase == $past(io_wr.data[3:0]))
				else $error("motor phases not loaded");
		end
	endgenerate

	// ==========================================================
	// Control, lamps and display
	io_out_reg u_control (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(control_sel),
		.din(io_wr.data),
		.q(control_reg)
	);
	io_out_reg u_lamps (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(lamps_sel),
		.din(io_wr.data),
		.q(lamps_reg)
	);
	io_out_reg u_segments (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(segments_sel),
		.din(io_wr.data),
		.q(segments_reg)
	);

	assign microstep_phase = control_reg[ENABLE_BIT] ? control_reg[3:0] : PHASE_OFF;
	assign hammer_fire = control_reg[HAMMER_BIT] && control_reg[ENABLE_BIT];
	assign motor_power_en = control_reg[ENABLE_BIT];
	assign panel_lamps = lamps_reg[3:0];
	assign segments_n = segments_reg;

	// ==========================================================
	// Print counter pulse, one cycle per write
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse <= 1'b0;
		end else begin
			pulse <= counter_sel;
		end
	end
	assign print_count_pulse = pulse;

	// ==========================================================
	// Input ports, registered
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sensor_port <= PORT_IDLE;
			switch_port <= PORT_IDLE;
		end else begin
			sensor_port <= {1'b1, sensor_n};
			switch_port <= switch_n;
		end
	end

	// ==========================================================
	// Checks
	sequence s_counter_write;
		io_wr.wr && io_wr.addr == ADDR_COUNTER;
	endsequence

	AST_COUNTER_PULSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_counter_write |=> print_count_pulse) else $error("print pulse missing");
	AST_PULSE_CAUSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		print_count_pulse |-> $past(io_wr.wr) && $past(io_wr.addr) == ADDR_COUNTER)
		else $error("spurious print pulse");
	AST_DAISY_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
		io_wr.wr && io_wr.addr == ADDR_DAISY |=> motor_drive[0].hold_n == $past(io_wr.data[4]))
		else $error("daisy hold not loaded");
	AST_RIBBON_PHASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		io_wr.wr && io_wr.addr == ADDR_RIBBON && control_reg[ENABLE_BIT]
		&& !control_sel |=> motor_drive[3].phase == $past(io_wr.data[3:0]))
		else $error("ribbon phases wrong");
	AST_HAMMER: assert property (@(posedge ref_clk) disable iff (!arst_n)
		io_wr.wr && io_wr.addr == ADDR_CONTROL |=> hammer_fire == ($past(io_wr.data[4])
		&& $past(io_wr.data[5]))) else $error("hammer wrong");
	AST_POWER_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!motor_power_en |-> motor_drive[1].phase == 4'h0 && microstep_phase == 4'h0)
		else $error("phases driven while disabled");
	AST_LAMP_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!lamps_sel |=> $stable(panel_lamps)) else $error("lamps changed without write");
	AST_SEGMENTS: assert property (@(posedge ref_clk) disable iff (!arst_n)
		segments_sel |=> segments_n == $past(io_wr.data)) else $error("segments wrong");
	AST_SWITCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
		1'b1 |=> switch_port == $past(switch_n)) else $error("switch port stale");

	// ==========================================================
	// Control register checks
	sequence s_control_write;
		control_sel;
	endsequence

	sequence s_lamps_write;
		lamps_sel;
	endsequence

	AST_POWER_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_control_write |=> motor_power_en == $past(io_wr.data[ENABLE_BIT]))
		else $error("motor enable not loaded");
	AST_MICROSTEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_control_write |=> microstep_phase == ($past(io_wr.data[ENABLE_BIT]) ?
		$past(io_wr.data[3:0]) : PHASE_OFF)) else $error("micro-step phases wrong");
	AST_HAMMER_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!motor_power_en |-> !hammer_fire) else $error("hammer fired while disabled");
	AST_CONTROL_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!control_sel |=> $stable(control_reg)) else $error("control changed without write");

	// ==========================================================
	// Lamp, display and unmapped-write checks
	AST_LAMPS_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_lamps_write |=> panel_lamps == $past(io_wr.data[3:0])) else $error("lamps wrong");
	AST_SEGMENT_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!segments_sel |=> $stable(segments_n)) else $error("display changed without write");
	AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!arst_n)
		io_wr.wr && !any_sel |=> $stable(control_reg) && $stable(lamps_reg)
		&& $stable(segments_reg) && !print_count_pulse)
		else $error("unmapped write had an effect");

	// ==========================================================
	// Pulse and input port checks
	AST_PULSE_ONE: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_counter_write ##1 !counter_sel |=> !print_count_pulse)
		else $error("print pulse too long");
	AST_SENSOR: assert property (@(posedge ref_clk) disable iff (!arst_n)
		1'b1 |=> sensor_port == {1'b1, $past(sensor_n)}) else $error("sensor port stale");
endmodule // printer_io_register_bank

// file: rtl/prn_io_pkg.sv
// Package of addresses, field layouts and reset values for the printer I/O bank
// How it works
// - Four write-only motor registers at 58..5B drive daisy, carriage, paper, ribbon.
// - Motor register bits 0-3 drive phases one to four, bit 4 hold line.
// - Register 5C: bits 0-3 micro-step phases, bit 4 hammer, bit 5 motor enable.
// - Reset drives phases low, motors held, hammer inactive.
// - Motor power removed whenever the enable bit is clear.
// - Sensor port bits 0-6: right, left margin, ribbon out, paper out, cover, home, type.
// - Switch port bits 0-7: select, roll up/down, feed up/down, load, top, enable.
// - Register 54 bits 0-3 drive select, change daisy, ribbon, paper lamps.
// - Register 5F drives segments A,F,E,D,C,G,B and decimal point, bits 0-7.
// - Any write to 5E gives one print-counter advance pulse.
package prn_io_pkg;
	localparam logic [7:0] ADDR_LAMPS = 8'h54;
	localparam logic [7:0] ADDR_DAISY = 8'h58;
	localparam logic [7:0] ADDR_CARRIAGE = 8'h59;
	localparam logic [7:0] ADDR_PAPER = 8'h5A;
	localparam logic [7:0] ADDR_RIBBON = 8'h5B;
	localparam logic [7:0] ADDR_CONTROL = 8'h5C;
	localparam logic [7:0] ADDR_COUNTER = 8'h5E;
	localparam logic [7:0] ADDR_SEGMENTS = 8'h5F;
	localparam int PHASE_LSB = 0;
	localparam int HOLD_BIT = 4;
	localparam int HAMMER_BIT = 4;
	localparam int ENABLE_BIT = 5;
	localparam int NUM_MOTORS = 4;
	// Hold line is active low, so reset value 00 leaves every motor held
	localparam logic [7:0] RESET_REG = 8'h00;
	// Input ports read all ones while reset, lines idle high
	localparam logic [7:0] PORT_IDLE = 8'hFF;
	// Phase pattern presented while motor power is off
	localparam logic [3:0] PHASE_OFF = 4'h0;

	typedef struct packed {
		logic [3:0] phase;
		logic hold_n;
	} motor_drive_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} io_write_t;
endpackage
